// ---- src/fcpwm_defines.vh ----
// register offsets, field positions, widths and reset values of the pwm
`ifndef FCPWM_DEFINES_VH
`define FCPWM_DEFINES_VH

// widths
`define FCPWM_CNT_W         10
`define FCPWM_CH_N          4
`define FCPWM_ADDR_W        8
`define FCPWM_DATA_W        8

// register offsets on the plain register port
`define FCPWM_PERIOD_HI     8'hD1
`define FCPWM_CH0_HI        8'hD2
`define FCPWM_CH1_HI        8'hD3
`define FCPWM_CH2_HI        8'hD4
`define FCPWM_CH3_HI        8'hD5
`define FCPWM_PERIOD_LO     8'hD9
`define FCPWM_CH0_LO        8'hDA
`define FCPWM_CH1_LO        8'hDB
`define FCPWM_GEN_CTRL      8'hDC
`define FCPWM_CH2_LO        8'hDD
`define FCPWM_CH3_LO        8'hDE
`define FCPWM_BRAKE_CTRL    8'hDF
`define FCPWM_BRAKE_STAT    8'hE3
`define FCPWM_IRQ_STAT      8'hF0
`define FCPWM_IRQ_MASK      8'hF1

// generator_control fields
`define FCPWM_RUN_BIT       7
`define FCPWM_LOAD_BIT      6
`define FCPWM_UFLOW_BIT     5
`define FCPWM_CLR_BIT       4

// brake_control fields
`define FCPWM_BSEL_BIT      7
`define FCPWM_BPOL_BIT      6
`define FCPWM_BRAKE_PIN_ENABLE_BIT      5
`define FCPWM_BEN_BIT       4

// brake status and interrupt fields
`define FCPWM_BFLAG_BIT     0
`define FCPWM_IRQ_UFLOW_BIT 0
`define FCPWM_IRQ_BRAKE_BIT 1
`define FCPWM_IRQ_W         2

// reset values
`define FCPWM_GEN_RST       8'h00
`define FCPWM_BRAKE_RST     8'h00
`define FCPWM_CNT_RST       10'h000
`define FCPWM_PERIOD_RST    10'h3FF
`define FCPWM_CMP_RST       10'h000

`endif

// ---- src/fcpwm_sync.v ----
// two flip-flop synchroniser for the brake input pin
`timescale 1ns/1ps
`default_nettype none

module fcpwm_sync (
   input  wire ref_clk_in,
   input  wire rst_in,
   input  wire async_in,
   output reg  sync_out
);

   reg meta;

   // first stage feeds only the second stage
   always @(posedge ref_clk_in) begin
      if (rst_in) begin
         meta     <= 1'b0;
         sync_out <= 1'b0;
      end else begin
         meta     <= async_in;
         sync_out <= meta;
      end
   end

endmodule // fcpwm_sync

`default_nettype wire

// ---- src/fcpwm_channel.v ----
// one pwm channel: compare, inversion and brake override onto the pin
`timescale 1ns/1ps
`default_nettype none

module fcpwm_channel #(
   parameter CNT_W = 10
) (
   input  wire             ref_clk_in,
   input  wire             rst_in,
   input  wire [CNT_W-1:0] count_in,
   input  wire [CNT_W-1:0] compare_in,
   input  wire             invert_in,
   input  wire             brake_in,
   input  wire             brake_level_in,
   output reg              pwm_out
);

   reg  raw;
   wire gen_level;

   // raw level is high while the counter sits below the compare value;
   // a stopped counter freezes it, which is what brake release restores
   always @(posedge ref_clk_in) begin
      if (rst_in) begin
         raw <= 1'b0;
      end else begin
         raw <= (count_in < compare_in); // [R16]
      end
   end

   assign gen_level = raw ^ invert_in; // [R6]

   // brake override last, so a release shows the generator at once
   always @(posedge ref_clk_in) begin
      if (rst_in) begin
         pwm_out <= 1'b0;
      end else if (brake_in) begin
         pwm_out <= brake_level_in; // [R10]
      end else begin
         pwm_out <= gen_level;
      end
   end

endmodule // fcpwm_channel

`default_nettype wire

// ---- src/fcpwm_top.v ----
// four channel pwm with shared down counter, buffered reload and brake
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "fcpwm_defines.vh"

// Behaviour
// [R1] counter runs only while run bit set
// [R2] load bit copies holding values at underflow
// [R3] load bit clears itself next cycle
// [R4] underflow sets sticky flag, software clears
// [R5] clear bit zeroes counter, then self clears
// [R6] invert bits flip each channel output
// [R7] ten-bit values split low byte, high bits
// [R8] polarity bit picks active brake pin level
// [R9] brake enable zero means never brake
// [R10] braked outputs take per-channel level bits
// [R11] mode 00: software brake, counter keeps running
// [R12] mode 01: brake only while stopped
// [R13] mode 10: pin brake stops run, sets flag
// [R14] pin brake release needs pin idle, enable off
// [R15] mode 11: no brake at all
// [R16] down count, reload at underflow, compare
module fcpwm_top (
   input  wire                     ref_clk_in,
   input  wire                     rst_in,
   input  wire [`FCPWM_ADDR_W-1:0] reg_addr_in,
   input  wire [`FCPWM_DATA_W-1:0] reg_wdata_in,
   input  wire                     reg_wr_in,
   input  wire                     reg_rd_in,
   input  wire                     brake_input_pin_in,
   output reg  [`FCPWM_DATA_W-1:0] reg_rdata_out,
   output wire [`FCPWM_CH_N-1:0]   pwm_out,
   output reg                      irq_out
);

   localparam CW = `FCPWM_CNT_W;
   localparam NC = `FCPWM_CH_N;
   // whole reset byte kept so single fields are picked by bit select
   localparam [`FCPWM_DATA_W-1:0] GEN_RST = `FCPWM_GEN_RST;

   ////////////////////////////////////////////////////////////////////////
   // register state

   reg          run_control;
   reg          load_request;
   reg          load_pending;
   reg          underflow_flag;
   reg          counter_clear;
   reg [NC-1:0] ch_invert;
   reg          brake_select;
   reg          brake_polarity;
   reg          brake_pin_enable;
   reg          brake_enable;
   reg [NC-1:0] ch_brake_level;
   reg          pin_brake_flag;
   reg          pin_brake_latch;
   reg [`FCPWM_IRQ_W-1:0] irq_status;
   reg [`FCPWM_IRQ_W-1:0] irq_mask;

   // holding values written by software, working values used by the
   // counter; channel n sits in bits n*CW+CW-1 down to n*CW
   reg [CW-1:0]    period_value;
   reg [NC*CW-1:0] channel_compare_value;
   reg [CW-1:0]    period_work;
   reg [NC*CW-1:0] compare_work;
   reg [CW-1:0]    count;

   wire pin_sync;
   wire pin_active;
   wire uflow_evt;
   wire sw_brake;
   wire stop_brake;
   wire pin_brake_on;
   wire pin_mode;
   wire brake;

   reg  [`FCPWM_DATA_W-1:0] next_rdata;
   reg  [`FCPWM_IRQ_W-1:0]  next_irq_status;

   ////////////////////////////////////////////////////////////////////////
   // helpers

   // channel index of a low-byte compare offset, or NC when none
   function [2:0] lo_index;
      input [`FCPWM_ADDR_W-1:0] a;
      begin
         case (a)
            `FCPWM_CH0_LO: lo_index = 3'h0;
            `FCPWM_CH1_LO: lo_index = 3'h1;
            `FCPWM_CH2_LO: lo_index = 3'h2;
            `FCPWM_CH3_LO: lo_index = 3'h3;
            default:       lo_index = 3'h4;
         endcase
      end
   endfunction

   // channel index of a high-bits compare offset, or NC when none
   function [2:0] hi_index;
      input [`FCPWM_ADDR_W-1:0] a;
      begin
         case (a)
            `FCPWM_CH0_HI: hi_index = 3'h0;
            `FCPWM_CH1_HI: hi_index = 3'h1;
            `FCPWM_CH2_HI: hi_index = 3'h2;
            `FCPWM_CH3_HI: hi_index = 3'h3;
            default:       hi_index = 3'h4;
         endcase
      end
   endfunction

   wire [2:0] wr_lo = lo_index(reg_addr_in);
   wire [2:0] wr_hi = hi_index(reg_addr_in);
   wire       wr_gen = reg_wr_in && (reg_addr_in == `FCPWM_GEN_CTRL);
   wire       wr_brk = reg_wr_in && (reg_addr_in == `FCPWM_BRAKE_CTRL);
   wire       wr_bst = reg_wr_in && (reg_addr_in == `FCPWM_BRAKE_STAT);

   ////////////////////////////////////////////////////////////////////////
   // brake pin and brake decision

   fcpwm_sync u_pin_sync (
      .ref_clk_in (ref_clk_in),
      .rst_in     (rst_in),
      .async_in   (brake_input_pin_in),
      .sync_out   (pin_sync)
   );

   // active level of the pin chosen by software
   assign pin_active = brake_polarity ? pin_sync : ~pin_sync; // [R8]

   // decode of the two mode bits, all gated by brake enable
   assign sw_brake = brake_enable && !brake_pin_enable
                     && !brake_select;                         // [R11]
   assign stop_brake = brake_enable && !brake_pin_enable
                       && brake_select && !run_control;        // [R12]
   assign pin_mode = brake_enable && brake_pin_enable
                     && !brake_select;                   // [R13] [R15]
   // pin brake holds on after the pin goes idle until enable drops
   assign pin_brake_on = pin_mode
                         && (pin_active || pin_brake_latch);   // [R14]
   assign brake = sw_brake || stop_brake || pin_brake_on;      // [R9]

   // latch of an observed pin brake; release needs enable off and pin idle
   always @(posedge ref_clk_in) begin
      if (rst_in) begin
         pin_brake_latch <= 1'b0;
      end else if (pin_mode && pin_active) begin
         pin_brake_latch <= 1'b1;
      end else if (!brake_enable && !pin_active) begin
         pin_brake_latch <= 1'b0; // [R14]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // shared down counter and buffered reload

   assign uflow_evt = run_control && !counter_clear
                      && (count == {CW{1'b0}});

   // clear beats counting; reload takes the new period when a load waits
   always @(posedge ref_clk_in) begin
      if (rst_in) begin
         count        <= `FCPWM_CNT_RST;
         period_work  <= `FCPWM_PERIOD_RST;
         compare_work <= {NC{`FCPWM_CMP_RST}};
         load_pending <= 1'b0;
      end else begin
         if (counter_clear) begin
            count <= {CW{1'b0}}; // [R5]
         end else if (uflow_evt) begin
            if (load_pending) begin
               count <= period_value; // [R2]
            end else begin
               count <= period_work; // [R16]
            end
         end else if (run_control) begin
            count <= count - {{(CW-1){1'b0}}, 1'b1}; // [R1]
         end
         // working copies change only on an underflow with a load waiting
         if (uflow_evt && load_pending) begin
            period_work  <= period_value; // [R2]
            compare_work <= channel_compare_value;
            load_pending <= 1'b0;
         end else if (load_request) begin
            load_pending <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // software writes and hardware side effects

   always @(posedge ref_clk_in) begin
      if (rst_in) begin
         run_control      <= GEN_RST[`FCPWM_RUN_BIT];
         load_request     <= 1'b0;
         underflow_flag   <= 1'b0;
         counter_clear    <= 1'b0;
         ch_invert        <= {NC{1'b0}};
         brake_select     <= 1'b0;
         brake_polarity   <= 1'b0;
         brake_pin_enable <= 1'b0;
         brake_enable     <= 1'b0;
         ch_brake_level   <= {NC{1'b0}};
         pin_brake_flag   <= 1'b0;
         period_value     <= `FCPWM_PERIOD_RST;
         channel_compare_value <= {NC{`FCPWM_CMP_RST}};
      end else begin
         // pin brake forces the run bit low, even against a write
         if (pin_brake_on) begin
            run_control <= 1'b0; // [R13]
         end else if (wr_gen) begin
            run_control <= reg_wdata_in[`FCPWM_RUN_BIT]; // [R1]
         end
         // self clearing strobes: visible for one cycle only
         load_request  <= wr_gen && reg_wdata_in[`FCPWM_LOAD_BIT]; // [R3]
         counter_clear <= wr_gen && reg_wdata_in[`FCPWM_CLR_BIT];  // [R5]
         if (wr_gen) begin
            ch_invert <= reg_wdata_in[NC-1:0]; // [R6]
         end
         // underflow flag: write 0 clears, a same-cycle event wins
         if (uflow_evt) begin
            underflow_flag <= 1'b1; // [R4]
         end else if (wr_gen && !reg_wdata_in[`FCPWM_UFLOW_BIT]) begin
            underflow_flag <= 1'b0; // [R4]
         end
         if (wr_brk) begin
            brake_select     <= reg_wdata_in[`FCPWM_BSEL_BIT];
            brake_polarity   <= reg_wdata_in[`FCPWM_BPOL_BIT];
            brake_pin_enable <= reg_wdata_in[`FCPWM_BRAKE_PIN_ENABLE_BIT];
            brake_enable     <= reg_wdata_in[`FCPWM_BEN_BIT];
            ch_brake_level   <= reg_wdata_in[NC-1:0];
         end
         // pin brake flag, software clears it by writing 0
         if (pin_brake_on) begin
            pin_brake_flag <= 1'b1; // [R13]
         end else if (wr_bst && !reg_wdata_in[`FCPWM_BFLAG_BIT]) begin
            pin_brake_flag <= 1'b0;
         end
         // ten-bit holding values written a byte or two bits at a time
         if (reg_wr_in && reg_addr_in == `FCPWM_PERIOD_LO) begin
            period_value[7:0] <= reg_wdata_in; // [R7]
         end
         if (reg_wr_in && reg_addr_in == `FCPWM_PERIOD_HI) begin
            period_value[CW-1:8] <= reg_wdata_in[CW-9:0]; // [R7]
         end
         if (reg_wr_in && wr_lo < NC) begin
            channel_compare_value[wr_lo*CW +: 8] <= reg_wdata_in; // [R7]
         end
         if (reg_wr_in && wr_hi < NC) begin
            channel_compare_value[wr_hi*CW+8 +: CW-8] <=
               reg_wdata_in[CW-9:0]; // [R7]
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // interrupt status, mask and output

   always @* begin
      next_irq_status = irq_status;
      if (reg_wr_in && reg_addr_in == `FCPWM_IRQ_STAT) begin
         next_irq_status = irq_status & ~reg_wdata_in[`FCPWM_IRQ_W-1:0];
      end
      // set after clear so a coincident event is kept
      if (uflow_evt) begin
         next_irq_status[`FCPWM_IRQ_UFLOW_BIT] = 1'b1;
      end
      if (pin_brake_on && !pin_brake_flag) begin
         next_irq_status[`FCPWM_IRQ_BRAKE_BIT] = 1'b1;
      end
   end

   // output registered, so it follows the status by one cycle
   always @(posedge ref_clk_in) begin
      if (rst_in) begin
         irq_status <= {`FCPWM_IRQ_W{1'b0}};
         irq_mask   <= {`FCPWM_IRQ_W{1'b0}};
         irq_out    <= 1'b0;
      end else begin
         irq_status <= next_irq_status;
         if (reg_wr_in && reg_addr_in == `FCPWM_IRQ_MASK) begin
            irq_mask <= reg_wdata_in[`FCPWM_IRQ_W-1:0];
         end
         irq_out <= |(irq_status & irq_mask);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read path: data stand only in the cycle after the strobe

   always @* begin
      next_rdata = {`FCPWM_DATA_W{1'b0}};
      case (reg_addr_in)
         `FCPWM_GEN_CTRL: begin
            next_rdata = {run_control, load_request, underflow_flag,
                          counter_clear, ch_invert};
         end
         `FCPWM_BRAKE_CTRL: begin
            next_rdata = {brake_select, brake_polarity, brake_pin_enable,
                          brake_enable, ch_brake_level};
         end
         `FCPWM_BRAKE_STAT: begin
            next_rdata[`FCPWM_BFLAG_BIT] = pin_brake_flag;
         end
         `FCPWM_PERIOD_LO: begin
            next_rdata = period_value[7:0];
         end
         `FCPWM_PERIOD_HI: begin
            next_rdata[CW-9:0] = period_value[CW-1:8];
         end
         `FCPWM_IRQ_STAT: begin
            next_rdata[`FCPWM_IRQ_W-1:0] = irq_status;
         end
         `FCPWM_IRQ_MASK: begin
            next_rdata[`FCPWM_IRQ_W-1:0] = irq_mask;
         end
         default: begin
            // compare registers; anything unmapped reads zero
            if (wr_lo < NC) begin
               next_rdata = channel_compare_value[wr_lo*CW +: 8];
            end else if (wr_hi < NC) begin
               next_rdata[CW-9:0] =
                  channel_compare_value[wr_hi*CW+8 +: CW-8];
            end
         end
      endcase
   end

   always @(posedge ref_clk_in) begin
      if (rst_in) begin
         reg_rdata_out <= {`FCPWM_DATA_W{1'b0}};
      end else if (reg_rd_in) begin
         reg_rdata_out <= next_rdata;
      end else begin
         reg_rdata_out <= {`FCPWM_DATA_W{1'b0}};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // channels

   genvar gi;
   generate
      for (gi = 0; gi < NC; gi = gi + 1) begin : g_ch
         fcpwm_channel #(
            .CNT_W (CW)
         ) u_ch (
            .ref_clk_in     (ref_clk_in),
            .rst_in         (rst_in),
            .count_in       (count),
            .compare_in     (compare_work[gi*CW +: CW]),
            .invert_in      (ch_invert[gi]),
            .brake_in       (brake),
            .brake_level_in (ch_brake_level[gi]),
            .pwm_out        (pwm_out[gi])
         );
      end
   endgenerate

endmodule // fcpwm_top

`default_nettype wire

// ---- bench/fcpwm_top_properties.sv ----
// checker for the pwm top: read port, brake levels and interrupt line
`timescale 1ns/1ps
`default_nettype none
`include "fcpwm_defines.vh"
module fcpwm_top_chk (
   input wire logic       ref_clk_in,
   input wire logic       rst_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic       reg_wr_in,
   input wire logic       reg_rd_in,
   input wire logic       brake_input_pin_in,
   input wire logic [7:0] reg_rdata_out,
   input wire logic [3:0] pwm_out,
   input wire logic       irq_out
);
   logic [7:0] df_sh;
   logic [1:0] msk_sh;
   logic       pin_act;
   logic       pin_mode;

   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);

   ////////////////////////////////////////////////////////////////////////
   // shadows of software-only registers; hardware never writes these two
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         df_sh  <= 8'h00;
         msk_sh <= 2'h0;
      end else if (reg_wr_in) begin
         if (reg_addr_in == `FCPWM_BRAKE_CTRL) df_sh <= reg_wdata_in;
         if (reg_addr_in == `FCPWM_IRQ_MASK) msk_sh <= reg_wdata_in[1:0];
      end
   end

   // pin brake mode and raw pin activity, before the synchroniser delay
   assign pin_act  = df_sh[6] ? brake_input_pin_in : !brake_input_pin_in;
   assign pin_mode = !df_sh[7] && (df_sh[5:4] == 2'h3);

   ////////////////////////////////////////////////////////////////////////
   a_rdata_idle: assert property (
      !$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
      else $error("read data not zero outside read answer");
   a_unmapped_zero: assert property (
      reg_rd_in && reg_addr_in == 8'h00 |=> reg_rdata_out == 8'h00)
      else $error("unmapped read not zero");
   a_brake_readback: assert property (
      reg_rd_in && reg_addr_in == `FCPWM_BRAKE_CTRL
      |=> reg_rdata_out == $past(df_sh))
      else $error("brake control readback wrong");
   a_mask_readback: assert property (
      reg_rd_in && reg_addr_in == `FCPWM_IRQ_MASK
      |=> reg_rdata_out == {6'h00, $past(msk_sh)})
      else $error("mask readback wrong");
   a_soft_brake_level: assert property (
      (df_sh[7:4] == 4'h1) [*2] |-> pwm_out == $past(df_sh[3:0]))
      else $error("software brake level not on pins");
   a_pin_brake_level: assert property (
      (pin_mode && pin_act) [*4] |-> pwm_out == $past(df_sh[3:0]))
      else $error("pin brake level not on pins");
   a_irq_mask_off: assert property (
      reg_wr_in && reg_addr_in == `FCPWM_IRQ_MASK
      && reg_wdata_in[1:0] == 2'h0 |-> ##2 !irq_out)
      else $error("interrupt high with mask clear");
   a_irq_rise_cause: assert property (
      $rose(irq_out) |-> $past(msk_sh) != 2'h0)
      else $error("interrupt rose with no mask bit");
endmodule // fcpwm_top_chk

bind fcpwm_top fcpwm_top_chk u_chk (
   .ref_clk_in         (ref_clk_in),
   .rst_in             (rst_in),
   .reg_addr_in        (reg_addr_in),
   .reg_wdata_in       (reg_wdata_in),
   .reg_wr_in          (reg_wr_in),
   .reg_rd_in          (reg_rd_in),
   .brake_input_pin_in (brake_input_pin_in),
   .reg_rdata_out      (reg_rdata_out),
   .pwm_out            (pwm_out),
   .irq_out            (irq_out)
);
`default_nettype wire

// ---- bench/fcpwm_pin_model.sv ----
// model of the external brake switch wired to the brake pin
`timescale 1ns/1ps
`default_nettype none
module fcpwm_pin_model (
   input  wire logic ref_clk_in,
   input  wire logic active_in,
   input  wire logic polarity_in,
   output var  logic brake_pin_out
);
   // the switch is a flop so the pin never moves in the sampling step
   initial brake_pin_out = 1'b1;
   always @(posedge ref_clk_in) begin
      brake_pin_out <= active_in ? polarity_in : !polarity_in;
   end
endmodule // fcpwm_pin_model
`default_nettype wire

// ---- bench/fcpwm_top_tb.sv ----
// testbench for the pwm top: registers, duty, brake modes, interrupt
`timescale 1ns/1ps
`default_nettype none
`include "fcpwm_defines.vh"
module fcpwm_top_tb;
   logic       ref_clk_in = 1'b0;
   logic       rst_in     = 1'b1;
   logic [7:0] addr       = 8'h00;
   logic [7:0] wdata      = 8'h00;
   logic       wr         = 1'b0;
   logic       rd         = 1'b0;
   logic       act        = 1'b0;
   logic       pol        = 1'b0;
   logic       pin;
   logic [7:0] rdata;
   logic [3:0] pwm;
   logic       irq;
   logic [7:0] v;
   logic [7:0] ones;
   int         failures   = 0;
   int         n_compared = 0;

   always #2.5 ref_clk_in = ~ref_clk_in;

   fcpwm_top u_dut (
      .ref_clk_in         (ref_clk_in),
      .rst_in             (rst_in),
      .reg_addr_in        (addr),
      .reg_wdata_in       (wdata),
      .reg_wr_in          (wr),
      .reg_rd_in          (rd),
      .brake_input_pin_in (pin),
      .reg_rdata_out      (rdata),
      .pwm_out            (pwm),
      .irq_out            (irq)
   );
   fcpwm_pin_model u_pin (
      .ref_clk_in    (ref_clk_in),
      .active_in     (act),
      .polarity_in   (pol),
      .brake_pin_out (pin)
   );

   ////////////////////////////////////////////////////////////////////////
   // compare, bus cycles and pin control
   task chk(input string what, input logic [7:0] e, input logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, e, g);
      end
   endtask
   task wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk_in);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge ref_clk_in);
      wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe edge
   task rd_chk(input string what, input logic [7:0] a, input logic [7:0] e);
      @(posedge ref_clk_in);
      addr <= a;
      rd   <= 1'b1;
      @(posedge ref_clk_in);
      rd <= 1'b0;
      #1;
      v = rdata;
      chk(what, e, v);
   endtask
   task settle(input int n);
      repeat (n) @(posedge ref_clk_in);
      #1;
   endtask
   task pwm_chk(input logic [3:0] e);
      settle(3);
      chk("pwm", {4'h0, e}, {4'h0, pwm});
   endtask
   task set_pin(input logic a, input logic p);
      @(posedge ref_clk_in);
      act <= a;
      pol <= p;
   endtask
   task end_sim;
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // whole run is under two hundred cycles; cut a hang well after that
   initial begin
      #20000;
      failures++;
      end_sim;
   end

   initial begin
      repeat (3) @(posedge ref_clk_in);
      rst_in <= 1'b0;
      rd_chk("gen", `FCPWM_GEN_CTRL, 8'h00);
      rd_chk("brk", `FCPWM_BRAKE_CTRL, 8'h00);
      rd_chk("plo", `FCPWM_PERIOD_LO, 8'hFF);
      rd_chk("phi", `FCPWM_PERIOD_HI, 8'h03);
      rd_chk("none", 8'h00, 8'h00);
      // stopped, compares zero: raw low, so pins show invert bits
      wr_reg(`FCPWM_GEN_CTRL, 8'h05);
      pwm_chk(4'h5);
      wr_reg(`FCPWM_BRAKE_CTRL, 8'h1A);
      pwm_chk(4'hA);
      wr_reg(`FCPWM_BRAKE_CTRL, 8'h00);
      pwm_chk(4'h5);
      wr_reg(`FCPWM_BRAKE_CTRL, 8'hBE);
      pwm_chk(4'h5);
      set_pin(1'b1, 1'b0);
      wr_reg(`FCPWM_BRAKE_CTRL, 8'h2A);
      pwm_chk(4'h5);
      set_pin(1'b0, 1'b0);
      // brake only while stopped
      wr_reg(`FCPWM_BRAKE_CTRL, 8'h9C);
      pwm_chk(4'hC);
      wr_reg(`FCPWM_GEN_CTRL, 8'h85);
      pwm_chk(4'h5);
      wr_reg(`FCPWM_GEN_CTRL, 8'h05);
      pwm_chk(4'hC);
      wr_reg(`FCPWM_BRAKE_CTRL, 8'h00);
      pwm_chk(4'h5);
      // period 3 and channel 0 compare 2 take effect only at underflow
      wr_reg(`FCPWM_PERIOD_LO, 8'h03);
      wr_reg(`FCPWM_PERIOD_HI, 8'h00);
      wr_reg(`FCPWM_CH0_LO, 8'h02);
      wr_reg(`FCPWM_CH0_HI, 8'h00);
      wr_reg(`FCPWM_IRQ_MASK, 8'h01);
      rd_chk("mask", `FCPWM_IRQ_MASK, 8'h01);
      wr_reg(`FCPWM_GEN_CTRL, 8'h50);
      rd_chk("selfclr", `FCPWM_GEN_CTRL, 8'h00);
      wr_reg(`FCPWM_GEN_CTRL, 8'h80);
      settle(12);
      ones = 8'h00;
      repeat (8) begin
         settle(1);
         ones = ones + {7'h00, pwm[0]};
      end
      chk("duty", 8'h04, ones);
      rd_chk("uflow", `FCPWM_GEN_CTRL, 8'hA0);
      rd_chk("irqst", `FCPWM_IRQ_STAT, 8'h01);
      chk("irq", 8'h01, {7'h00, irq});
      wr_reg(`FCPWM_IRQ_MASK, 8'h00);
      settle(2);
      chk("irq", 8'h00, {7'h00, irq});
      wr_reg(`FCPWM_GEN_CTRL, 8'h00);
      wr_reg(`FCPWM_IRQ_STAT, 8'h01);
      rd_chk("irqst", `FCPWM_IRQ_STAT, 8'h00);
      // pin brake with each polarity; it latches until enable is cleared
      for (int p = 0; p < 2; p++) begin
         set_pin(1'b0, p[0]);
         wr_reg(`FCPWM_IRQ_MASK, 8'h02);
         wr_reg(`FCPWM_GEN_CTRL, 8'h80);
         wr_reg(`FCPWM_BRAKE_CTRL, {1'b0, p[0], 6'h39});
         set_pin(1'b1, p[0]);
         settle(4);
         pwm_chk(4'h9);
         // counter ran almost two periods of 4 first, so underflow is set
         rd_chk("run", `FCPWM_GEN_CTRL, 8'h20);
         rd_chk("bflag", `FCPWM_BRAKE_STAT, 8'h01);
         chk("irq", 8'h01, {7'h00, irq});
         set_pin(1'b0, p[0]);
         pwm_chk(4'h9);
         wr_reg(`FCPWM_BRAKE_CTRL, 8'h00);
         settle(3);
         chk("rel", 8'h00, {4'h0, pwm & 4'hE});
         wr_reg(`FCPWM_BRAKE_STAT, 8'h00);
         wr_reg(`FCPWM_IRQ_STAT, 8'h03);
         rd_chk("bflag", `FCPWM_BRAKE_STAT, 8'h00);
         chk("irq", 8'h00, {7'h00, irq});
      end
      end_sim;
   end
endmodule // fcpwm_top_tb
`default_nettype wire
